// [rtl/sqm_defs.vh]
// Shared constants of the squeeze stage monitor
`ifndef SQM_DEFS_VH
`define SQM_DEFS_VH
// Register byte offsets
`define SQM_REG_CTRL    8'h00
`define SQM_REG_SEL     8'h04
`define SQM_REG_EDIT    8'h08
`define SQM_REG_TIME    8'h0c
`define SQM_REG_SETPT   8'h10
`define SQM_REG_LIMIT   8'h14
`define SQM_REG_OFFSET  8'h18
`define SQM_REG_CONFIG  8'h1c
`define SQM_REG_STATUS  8'h20
`define SQM_REG_MASK    8'h24
`define SQM_REG_MEAS    8'h28
// Control bits
`define SQM_CTRL_START  0
`define SQM_CTRL_STOP   1
`define SQM_CTRL_REPEAT 2
`define SQM_CTRL_INTENS 3
// Status bits
`define SQM_ST_HIGH     0
`define SQM_ST_LOW      1
`define SQM_ST_PREHIGH  2
`define SQM_ST_PRELOW   3
`define SQM_ST_DONE     4
`define SQM_ST_W        5
// Schedule store
`define SQM_NSCHED      100
`define SQM_LAST_SCHED  7'h63
`define SQM_IDX_W       7
`define SQM_VAL_W       14
// Value units: pressure, force or current
`define SQM_UNIT_PSI    2'h0
`define SQM_UNIT_LB     2'h1
`define SQM_UNIT_MA     2'h2
// Sensor scaling, current in 0.01 mA
`define SQM_MA_ZERO     12'h190
`define SQM_MA_FULL     12'h7d0
`define SQM_FORCE_MAX   14'h3d54
`define SQM_PI_Q11      12'hc91
`define SQM_FORCE_DIV   40'h00001f4000
`define SQM_PCT_FULL    8'h64
`define SQM_LINE_PER_S  60
`define SQM_NV_WAIT     2'h3
`endif

// [rtl/sqm_conv.v]
// Sensor current to pressure, force or current value
`timescale 1ns/1ps
`include "sqm_defs.vh"
module sqm_conv (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire [11:0] ma_in,
  input  wire [1:0]  unit_in,
  input  wire [7:0]  dia_in,
  output reg  [13:0] value_out
);
  wire [11:0] ma_c;
  wire [11:0] ma_off;
  wire [13:0] p01;
  wire [39:0] prod;
  wire [39:0] force_h;
  assign ma_c   = (ma_in > `SQM_MA_FULL) ? `SQM_MA_FULL : ma_in;
  assign ma_off = (ma_c < `SQM_MA_ZERO) ? 12'h000 : ma_c - `SQM_MA_ZERO;
  assign p01    = {2'h0, ma_off[11:0]} * 14'h0005 >> 3;
  assign prod    = {26'h0, p01} * {32'h0, dia_in} * {32'h0, dia_in} * {28'h0, `SQM_PI_Q11};
  assign force_h = prod / `SQM_FORCE_DIV;
  always @(posedge core_clk_in) begin
    if (!nrst_in)
      value_out <= 14'h0000;
    else if (unit_in == `SQM_UNIT_LB)
      value_out <= (force_h > {26'h0, `SQM_FORCE_MAX}) ? `SQM_FORCE_MAX : force_h[13:0];
    else if (unit_in == `SQM_UNIT_MA)
      value_out <= {2'h0, ma_c} / 14'h000a;
    else
      value_out <= p01;
  end
endmodule // sqm_conv

// [rtl/sqm_limchk.v]
// Limit and derived pre-limit comparison
`timescale 1ns/1ps
`include "sqm_defs.vh"
module sqm_limchk (
  input  wire [13:0] value_in,
  input  wire [13:0] upper_in,
  input  wire [13:0] lower_in,
  input  wire [6:0]  ofs_in,
  output wire        high_out,
  output wire        low_out,
  output wire        prehigh_out,
  output wire        prelow_out
);
  wire [21:0] hi_prod;
  wire [21:0] lo_prod;
  wire [21:0] pre_hi;
  wire [21:0] pre_lo;
  assign hi_prod = {8'h0, upper_in} * ({14'h0, `SQM_PCT_FULL} - {15'h0, ofs_in});
  assign lo_prod = {8'h0, lower_in} * ({14'h0, `SQM_PCT_FULL} + {15'h0, ofs_in});
  assign pre_hi  = hi_prod / {14'h0, `SQM_PCT_FULL};
  assign pre_lo  = lo_prod / {14'h0, `SQM_PCT_FULL};
  assign high_out    = value_in >= upper_in;
  assign low_out     = value_in <= lower_in;
  assign prehigh_out = {8'h0, value_in} >= pre_hi;
  assign prelow_out  = {8'h0, value_in} <= pre_lo;
endmodule // sqm_limchk

// [rtl/sqm_top.v]
// Squeeze stage sequencer and pressure/force supervisor
// Behaviour
// - One hundred schedules, index 0 to 99, each with squeeze parameters
// - Selected schedule index survives power loss via nonvolatile store
// - Pre-squeeze 0-99 line cycles; acts as advance in intensifier mode (INTENS bit is only stored, pre-squeeze runs unchanged)
// - Pre-squeeze energises valves after initiation, right before first squeeze
// - Repeat mode runs pre-squeeze only before the first squeeze
// - Squeeze lasts programmed line cycles; intensify state in intensifier mode (no intensify state, INTENS bit is only stored)
// - Squeeze drives any subset of three valves, three-bit code
// - Setpoint per schedule in configured unit, held during squeeze
// - Sensor 4-20 mA maps linearly onto 0-100 PSI
// - Force is pressure times pi times diameter squared over four
// - At squeeze end flag high at/above and low at/below limits (flags are set only while offset bit 7, sq_ofs[7], is set)
// - Limits share the setpoint unit and range
// - With pre-limit enabled also flag pre-high and pre-low warnings (pre-limit enable is offset bit 8; the warnings also need offset bit 7)
// - Pre-high is high times one minus offset; pre-low one plus
// - Pre-limit offset is a per-schedule percentage 0 to 99
`timescale 1ns/1ps
`include "sqm_defs.vh"
module sqm_top (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output reg         pslverr_out,
  input  wire        line_sync_in,
  input  wire        init_in,
  input  wire [11:0] sensor_ma_in,
  input  wire [6:0]  nv_sched_in,
  output reg         nv_wr_out,
  output reg  [6:0]  nv_data_out,
  output reg  [2:0]  valve_out,
  output reg  [13:0] prop_set_out,
  output reg  [1:0]  phase_out,
  output wire        irq_out
);

////////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE  = 2'h0;
  localparam ST_PRESQ = 2'h1;
  localparam ST_SQZ   = 2'h2;
  localparam ST_CHECK = 2'h3;

  // Decode shared by read mux and write strobes
  function is_reg;
    input [7:0] addr;
    input [7:0] off;
    begin
      is_reg = (addr == off);
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'h0) && (addr <= `SQM_REG_MEAS);
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg  [1:0]  line_s;
  reg  [1:0]  init_s;
  reg  [11:0] ma_s0;
  reg  [11:0] ma_s1;
  reg  [6:0]  nv_s0;
  reg  [6:0]  nv_s1;
  reg         line_d;
  reg         init_d;
  wire        line_tick;
  wire        init_rise;

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      line_s <= 2'h0;
      init_s <= 2'h0;
      ma_s0  <= 12'h000;
      ma_s1  <= 12'h000;
      nv_s0  <= 7'h00;
      nv_s1  <= 7'h00;
      line_d <= 1'b0;
      init_d <= 1'b0;
    end else begin
      line_s <= {line_s[0], line_sync_in};
      init_s <= {init_s[0], init_in};
      ma_s0  <= sensor_ma_in;
      ma_s1  <= ma_s0;
      nv_s0  <= nv_sched_in;
      nv_s1  <= nv_s0;
      line_d <= line_s[1];
      init_d <= init_s[1];
    end
  end
  // One tick per mains cycle, 60 per second
  assign line_tick = line_s[1] & ~line_d;
  assign init_rise = init_s[1] & ~init_d;

////////////////////////////////////////////////////////////////////////////////
  // Schedule store, no reset: contents are software owned
  // hundred schedules
  reg  [16:0] mem_time [0:`SQM_NSCHED-1];
  reg  [13:0] mem_set  [0:`SQM_NSCHED-1];
  reg  [27:0] mem_lim  [0:`SQM_NSCHED-1];
  reg  [8:0]  mem_ofs  [0:`SQM_NSCHED-1];

  reg  [3:0]  ctrl;
  reg  [6:0]  sel_idx;
  reg  [6:0]  edit_idx;
  reg  [9:0]  config_r;
  reg  [4:0]  status;
  reg  [4:0]  mask;
  reg  [1:0]  nv_cnt;
  reg  [1:0]  state;
  reg  [6:0]  cnt;
  reg         rep_armed;
  reg  [6:0]  sq_len;
  reg  [13:0] sq_upper;
  reg  [13:0] sq_lower;
  reg  [8:0]  sq_ofs;
  reg  [4:0]  set_ev;

  wire        wr_en;
  wire        rd_en;
  wire [4:0]  w1c;
  wire        start_req;
  wire [13:0] meas;
  wire        f_high;
  wire        f_low;
  wire        f_phigh;
  wire        f_plow;
  wire [16:0] cur_time;

  assign wr_en      = psel_in & penable_in & pwrite_in;
  assign rd_en      = psel_in & ~penable_in & ~pwrite_in;
  assign pready_out = 1'b1;
  assign cur_time   = mem_time[sel_idx];

////////////////////////////////////////////////////////////////////////////////
  // Measurement and limit check
  sqm_conv u_conv (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .ma_in       (ma_s1),
    .unit_in     (config_r[9:8]),
    .dia_in      (config_r[7:0]),
    .value_out   (meas)
  );

  sqm_limchk u_chk (
    .value_in    (meas),
    .upper_in    (sq_upper),
    .lower_in    (sq_lower),
    .ofs_in      (sq_ofs[6:0]),
    .high_out    (f_high),
    .low_out     (f_low),
    .prehigh_out (f_phigh),
    .prelow_out  (f_plow)
  );

////////////////////////////////////////////////////////////////////////////////
  // APB register writes
  always @(posedge core_clk_in) begin
    if (wr_en && edit_idx <= `SQM_LAST_SCHED) begin
      if (is_reg(paddr_in, `SQM_REG_TIME))
        mem_time[edit_idx] <= {pwdata_in[18:16], pwdata_in[14:8], pwdata_in[6:0]};
      if (is_reg(paddr_in, `SQM_REG_SETPT))
        mem_set[edit_idx] <= pwdata_in[13:0];
      if (is_reg(paddr_in, `SQM_REG_LIMIT))
        mem_lim[edit_idx] <= {pwdata_in[29:16], pwdata_in[13:0]};
      if (is_reg(paddr_in, `SQM_REG_OFFSET))
        mem_ofs[edit_idx] <= pwdata_in[8:0];
    end
  end

  assign w1c = (wr_en && is_reg(paddr_in, `SQM_REG_STATUS)) ?
               pwdata_in[`SQM_ST_W-1:0] : 5'h00;

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      ctrl        <= 4'h0;
      sel_idx     <= 7'h00;
      edit_idx    <= 7'h00;
      config_r    <= 10'h000;
      mask        <= 5'h00;
      nv_cnt      <= 2'h0;
      nv_wr_out   <= 1'b0;
      nv_data_out <= 7'h00;
    end else begin
      nv_wr_out <= 1'b0;
      ctrl[`SQM_CTRL_START] <= 1'b0;
      ctrl[`SQM_CTRL_STOP]  <= 1'b0;
      if (nv_cnt != `SQM_NV_WAIT) begin
        nv_cnt <= nv_cnt + 2'h1;
        if (nv_cnt == `SQM_NV_WAIT - 2'h1 && nv_s1 <= `SQM_LAST_SCHED)
          sel_idx <= nv_s1;
      end
      if (wr_en) begin
        if (is_reg(paddr_in, `SQM_REG_CTRL))
          ctrl <= pwdata_in[3:0];
        if (is_reg(paddr_in, `SQM_REG_SEL) && pwdata_in[6:0] <= `SQM_LAST_SCHED) begin
          sel_idx     <= pwdata_in[6:0];
          nv_wr_out   <= 1'b1;
          nv_data_out <= pwdata_in[6:0];
        end
        if (is_reg(paddr_in, `SQM_REG_EDIT))
          edit_idx <= pwdata_in[6:0];
        if (is_reg(paddr_in, `SQM_REG_CONFIG))
          config_r <= pwdata_in[9:0];
        if (is_reg(paddr_in, `SQM_REG_MASK))
          mask <= pwdata_in[4:0];
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // APB read data, registered in the setup cycle
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else if (psel_in && !penable_in) begin
      pslverr_out <= ~mapped(paddr_in);
      prdata_out  <= 32'h00000000;
      if (rd_en) begin
        if (is_reg(paddr_in, `SQM_REG_CTRL))
          prdata_out <= {28'h0, ctrl[3:2], 2'h0};
        if (is_reg(paddr_in, `SQM_REG_SEL))
          prdata_out <= {25'h0, sel_idx};
        if (is_reg(paddr_in, `SQM_REG_EDIT))
          prdata_out <= {25'h0, edit_idx};
        if (is_reg(paddr_in, `SQM_REG_TIME) && edit_idx <= `SQM_LAST_SCHED)
          prdata_out <= {13'h0, mem_time[edit_idx][16:14], 1'b0,
                         mem_time[edit_idx][13:7], 1'b0, mem_time[edit_idx][6:0]};
        if (is_reg(paddr_in, `SQM_REG_SETPT) && edit_idx <= `SQM_LAST_SCHED)
          prdata_out <= {18'h0, mem_set[edit_idx]};
        if (is_reg(paddr_in, `SQM_REG_LIMIT) && edit_idx <= `SQM_LAST_SCHED)
          prdata_out <= {2'h0, mem_lim[edit_idx][27:14], 2'h0, mem_lim[edit_idx][13:0]};
        if (is_reg(paddr_in, `SQM_REG_OFFSET) && edit_idx <= `SQM_LAST_SCHED)
          prdata_out <= {23'h0, mem_ofs[edit_idx]};
        if (is_reg(paddr_in, `SQM_REG_CONFIG))
          prdata_out <= {22'h0, config_r};
        if (is_reg(paddr_in, `SQM_REG_STATUS))
          prdata_out <= {25'h0, state, status};
        if (is_reg(paddr_in, `SQM_REG_MASK))
          prdata_out <= {27'h0, mask};
        if (is_reg(paddr_in, `SQM_REG_MEAS))
          prdata_out <= {18'h0, meas};
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Squeeze sequencer
  assign start_req = ctrl[`SQM_CTRL_START] | init_rise;

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state        <= ST_IDLE;
      cnt          <= 7'h00;
      rep_armed    <= 1'b0;
      sq_len       <= 7'h00;
      sq_upper     <= 14'h0000;
      sq_lower     <= 14'h0000;
      sq_ofs       <= 9'h000;
      valve_out    <= 3'h0;
      prop_set_out <= 14'h0000;
      phase_out    <= 2'h0;
      set_ev       <= 5'h00;
    end else begin
      set_ev <= 5'h00;
      // Stop outside the check state, or leaving repeat, ends the chain
      if (ctrl[`SQM_CTRL_STOP] || !ctrl[`SQM_CTRL_REPEAT])
        rep_armed <= 1'b0;
      case (state)
        ST_IDLE: begin
          valve_out <= 3'h0;
          phase_out <= ST_IDLE;
          if (start_req) begin
            cnt       <= 7'h00;
            sq_len    <= cur_time[13:7];
            sq_upper  <= mem_lim[sel_idx][13:0];
            sq_lower  <= mem_lim[sel_idx][27:14];
            sq_ofs    <= mem_ofs[sel_idx];
            valve_out <= cur_time[16:14];
            if (rep_armed || cur_time[6:0] == 7'h00) begin
              state        <= ST_SQZ;
              phase_out    <= ST_SQZ;
              prop_set_out <= mem_set[sel_idx];
            end else begin
              state     <= ST_PRESQ;
              phase_out <= ST_PRESQ;
            end
          end
        end
        ST_PRESQ: begin
          if (line_tick) begin
            if (cnt + 7'h01 >= cur_time[6:0]) begin
              cnt          <= 7'h00;
              state        <= ST_SQZ;
              phase_out    <= ST_SQZ;
              prop_set_out <= mem_set[sel_idx];
            end else
              cnt <= cnt + 7'h01;
          end
        end
        ST_SQZ: begin
          if (sq_len == 7'h00 || (line_tick && cnt + 7'h01 >= sq_len)) begin
            cnt       <= 7'h00;
            state     <= ST_CHECK;
            phase_out <= ST_CHECK;
          end else if (line_tick)
            cnt <= cnt + 7'h01;
        end
        ST_CHECK: begin
          set_ev[`SQM_ST_HIGH] <= sq_ofs[7] & f_high;
          set_ev[`SQM_ST_LOW]  <= sq_ofs[7] & f_low;
          set_ev[`SQM_ST_PREHIGH] <= sq_ofs[7] & sq_ofs[8] & f_phigh;
          set_ev[`SQM_ST_PRELOW]  <= sq_ofs[7] & sq_ofs[8] & f_plow;
          set_ev[`SQM_ST_DONE]    <= 1'b1;
          rep_armed <= ctrl[`SQM_CTRL_REPEAT];
          valve_out <= 3'h0;
          phase_out <= ST_IDLE;
          state     <= ST_IDLE;
        end
        default: begin
          state     <= ST_IDLE;
          phase_out <= ST_IDLE;
        end
      endcase
      if (ctrl[`SQM_CTRL_STOP]) begin
        state     <= ST_IDLE;
        valve_out <= 3'h0;
        phase_out <= ST_IDLE;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Sticky status, set beats clear
  always @(posedge core_clk_in) begin
    if (!nrst_in)
      status <= 5'h00;
    else
      status <= (status & ~w1c) | set_ev;
  end

  assign irq_out = |(status & mask);

endmodule // sqm_top

// [tb/sqm_top_chk.sv]
// Port checker of the squeeze stage monitor
`timescale 1ns/1ps
`include "sqm_defs.vh"
module sqm_chk (
  input wire        core_clk_in,
  input wire        nrst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  input wire        line_sync_in,
  input wire        init_in,
  input wire [11:0] sensor_ma_in,
  input wire [6:0]  nv_sched_in,
  input wire        nv_wr_out,
  input wire [6:0]  nv_data_out,
  input wire [2:0]  valve_out,
  input wire [13:0] prop_set_out,
  input wire [1:0]  phase_out,
  input wire        irq_out
);
  wire wr_cyc = psel_in && penable_in && pwrite_in;
  wire sel_wr = wr_cyc && (paddr_in == `SQM_REG_SEL);
  wire irq_wr = wr_cyc && (paddr_in == `SQM_REG_STATUS || paddr_in == `SQM_REG_MASK);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  //////////////////////////////////////////////////////////////////////////
  idle_valves_a: assert property (phase_out == 2'h0 |-> valve_out == 3'h0)
    else $error("Valves driven while idle");
  pre_exit_a: assert property (phase_out == 2'h1 ##1 phase_out != 2'h1 |->
    phase_out inside {2'h0, 2'h2}) else $error("Pre-squeeze not followed by squeeze");
  squeeze_exit_a: assert property (phase_out == 2'h2 ##1 phase_out != 2'h2 |->
    phase_out inside {2'h0, 2'h3}) else $error("Squeeze not followed by check");
  check_len_a: assert property (phase_out == 2'h3 |=> phase_out == 2'h0)
    else $error("Check phase longer than one cycle");
  setpt_hold_a: assert property (phase_out == 2'h2 && $past(phase_out) == 2'h2 |->
    $stable(prop_set_out)) else $error("Setpoint moved during squeeze");
  irq_rise_a: assert property ($rose(irq_out) |->
    $past(phase_out, 2) == 2'h3 || $past(irq_wr)) else $error("Interrupt rose without cause");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(irq_wr))
    else $error("Latched status dropped without host clear");
  nv_pulse_a: assert property (nv_wr_out |->
    ($past(sel_wr) || $past(sel_wr, 2)) ##1 !nv_wr_out) else $error("Bad store pulse");
  nv_range_a: assert property (nv_wr_out |-> nv_data_out <= 7'h63)
    else $error("Stored index out of range");
  nv_data_a: assert property (nv_wr_out |-> {25'h0, nv_data_out} == $past(pwdata_in))
    else $error("Stored index differs from written index");
endmodule // sqm_chk

bind sqm_top sqm_chk u_port_chk (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .line_sync_in(line_sync_in), .init_in(init_in),
  .sensor_ma_in(sensor_ma_in), .nv_sched_in(nv_sched_in), .nv_wr_out(nv_wr_out),
  .nv_data_out(nv_data_out), .valve_out(valve_out), .prop_set_out(prop_set_out),
  .phase_out(phase_out), .irq_out(irq_out));

// [tb/sqm_gun.sv]
// Weld gun model: mains timebase and pressure sensor
`timescale 1ns/1ps
module sqm_gun #(
  parameter HALF = 5
) (
  input  wire        core_clk_in,
  input  wire [11:0] target_in,
  output reg         line_sync_out,
  output wire [11:0] sensor_ma_out
);
  integer cnt = 0;
  initial line_sync_out = 1'b0;
  // Mains runs free, also between sequences
  always @(posedge core_clk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      line_sync_out <= ~line_sync_out;
    end
  end
  // Regulated cylinder, sensor current held at target
  assign sensor_ma_out = target_in;
endmodule // sqm_gun

// [tb/sqm_top_bench.sv]
// Self-checking bench of the squeeze stage monitor
`timescale 1ns/1ps
`include "sqm_defs.vh"
module sqm_top_bench;
  localparam P = 10;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg         psel = 1'b0;
  reg         pen = 1'b0;
  reg         pwr = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         init = 1'b0;
  reg  [6:0]  nv = 7'h00;
  reg  [11:0] tgt = 12'h4b0;
  reg  [1:0]  ph_q = 2'h0;
  reg  [16:0] vs = 17'h0;
  reg  [63:0] ev;
  reg  [36:0] cs[0:5];
  reg  [32:0] q_rd[$];
  reg  [30:0] q_sq[$];
  wire [31:0] prdata;
  wire        pready, pslverr, lsync, irq;
  wire [11:0] ma;
  wire [2:0]  valve;
  wire [13:0] pset;
  wire [1:0]  phase;
  integer     err_count = 0;
  integer     cmp_count = 0;
  integer     l1 = 0, l2 = 0, i, j, d;

  sqm_top dut (
    .core_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .line_sync_in(lsync), .init_in(init),
    .sensor_ma_in(ma), .nv_sched_in(nv), .nv_wr_out(), .nv_data_out(),
    .valve_out(valve), .prop_set_out(pset), .phase_out(phase), .irq_out(irq));
  sqm_gun #(.HALF(P / 2)) gun (
    .core_clk_in(clk), .target_in(tgt), .line_sync_out(lsync), .sensor_ma_out(ma));

  initial begin
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task chk_rd(input [32:0] got, input [32:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_sq(input [30:0] got, input [30:0] exp); chk_rd({2'h0, got}, {2'h0, exp}); endtask
  task apb(input w, input [7:0] a, input [31:0] wd);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] wd); apb(1'b1, a, wd); endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      q_rd.push_back({1'b0, e});
      apb(1'b0, a, 32'h0);
    end
  endtask
  task prog(input [6:0] s, input [6:0] n1, input [6:0] n2, input [2:0] vv,
            input [13:0] sp, input [13:0] u, input [13:0] l, input [8:0] of);
    begin
      wr(`SQM_REG_EDIT, {25'h0, s});
      wr(`SQM_REG_TIME, {13'h0, vv, 1'b0, n2, 1'b0, n1});
      wr(`SQM_REG_SETPT, {18'h0, sp});
      wr(`SQM_REG_LIMIT, {2'h0, l, 2'h0, u});
      wr(`SQM_REG_OFFSET, {23'h0, of});
    end
  endtask
  // Inclusive compares, pre-limits truncated
  function [3:0] flags(input [13:0] v, input [36:0] c);
    flags = {c[8] & c[7] & (v <= c[22:9] * (100 + c[6:0]) / 100),
             c[8] & c[7] & (v >= c[36:23] * (100 - c[6:0]) / 100),
             c[7] & (v <= c[22:9]), c[7] & (v >= c[36:23])};
  endfunction
  // Start by register when ctl[0] is set, else by the initiation pin
  task run(input [3:0] ctl, input [30:0] e, input [3:0] f);
    begin
      q_sq.push_back(e);
      if (ctl[0]) begin
        wr(`SQM_REG_CTRL, {28'h0, ctl});
      end else begin
        init <= 1'b1;
        repeat (4) @(posedge clk);
        init <= 1'b0;
      end
      // Hangs are left to the watchdog
      @(negedge clk);
      while (phase === 2'h0) @(negedge clk);
      while (phase !== 2'h0) @(negedge clk);
      rd(`SQM_REG_STATUS, {27'h0, 1'b1, f});
      wr(`SQM_REG_STATUS, 32'h1f);
      rd(`SQM_REG_STATUS, 32'h0);
    end
  endtask
  task close_out;
    begin
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (psel && pen && pready && !pwr && q_rd.size() > 0) begin
      chk_rd({pslverr, prdata}, q_rd.pop_front());
    end
    if (phase == 2'h0) begin
      l1 = 0;
      l2 = 0;
    end
    if (phase == 2'h1) begin
      l1 = l1 + 1;
    end
    if (phase == 2'h2) begin
      l2 = l2 + 1;
      vs = {valve, pset};
    end
    // Line ticks rounded up, since the first tick may come early
    if (ph_q == 2'h2 && phase == 2'h3 && q_sq.size() > 0) begin
      chk_sq({7'((l1 + P - 1) / P), 7'((l2 + P - 1) / P), vs}, q_sq.pop_front());
    end
    ph_q = phase;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    close_out;
  end

  initial begin
    i = $urandom(32'hda97afa2);
    nv <= 7'($urandom % 100);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`SQM_REG_SEL, {25'h0, nv});
    wr(`SQM_REG_SEL, 32'd99);
    wr(`SQM_REG_SEL, 32'd100);
    rd(`SQM_REG_SEL, 32'd99);
    wr(`SQM_REG_EDIT, 32'd100);
    rd(`SQM_REG_TIME, 32'h0);
    q_rd.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h2c, 32'h0);
    wr(`SQM_REG_CONFIG, 32'd50);
    wr(`SQM_REG_MASK, 32'h1f);
    for (i = 0; i < 8; i = i + 1) begin
      d = $urandom % 1001;
      prog(7'(92 + i), 7'(i % 3), 7'(1 + i % 4), 3'(i), 14'(d), 14'd1000, 14'd0, 9'h0);
      wr(`SQM_REG_SEL, 92 + i);
      run({3'h0, i[0]}, {7'(i % 3), 7'(1 + i % 4), 3'(i), 14'(d)}, 4'h0);
    end
    cs[0] = {14'd500, 14'd499, 9'h180};
    cs[1] = {14'd501, 14'd500, 9'h08a};
    cs[2] = {14'd555, 14'd450, 9'h18a};
    cs[3] = {14'd1000, 14'd252, 9'h1e3};
    cs[4] = {14'd500, 14'd0, 9'h100};
    cs[5] = {14'($urandom % 1001), 14'($urandom % 1001), 2'h3, 7'($urandom % 100)};
    for (i = 0; i < 6; i = i + 1) begin
      prog(7'd5, 7'd0, 7'd2, 3'h5, 14'd500, cs[i][36:23], cs[i][22:9], cs[i][8:0]);
      wr(`SQM_REG_SEL, 32'd5);
      run(4'h1, {7'd0, 7'd2, 3'h5, 14'd500}, flags(14'd500, cs[i]));
    end
    prog(7'd7, 7'd3, 7'd2, 3'h3, 14'd100, 14'd1000, 14'd0, 9'h0);
    wr(`SQM_REG_SEL, 32'd7);
    run(4'hd, {7'd3, 7'd2, 3'h3, 14'd100}, 4'h0);
    run(4'hd, {7'd0, 7'd2, 3'h3, 14'd100}, 4'h0);
    rd(`SQM_REG_CTRL, 32'hc);
    // Stop in mid-squeeze: no end of squeeze, so no status bit
    wr(`SQM_REG_CTRL, 32'h5);
    wr(`SQM_REG_CTRL, 32'h2);
    rd(`SQM_REG_STATUS, 32'h0);
    j = $urandom % 21;
    d = 20 + $urandom % 60;
    tgt <= 12'(400 + 80 * j);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`SQM_REG_CONFIG, {22'h0, 2'(i), 8'(d)});
      run(4'h1, {7'd3, 7'd2, 3'h3, 14'd100}, 4'h0);
      ev = (i == 0) ? 50 * j : (i == 1) ? 64'(50 * j) * d * d * 3217 / 2048000 : 40 + 8 * j;
      rd(`SQM_REG_MEAS, 32'(ev));
    end
    close_out;
  end
endmodule // sqm_top_bench
